// File: core/cpu8_params.svh
`ifndef CPU8_PARAMS_SVH
`define CPU8_PARAMS_SVH
// literal group, upper instruction byte
`define OP_ADD_LIT 8'h0f
`define OP_SUB_LIT 8'h08
`define OP_AND_LIT 8'h0b
`define OP_OR_LIT 8'h09
`define OP_XOR_LIT 8'h0a
`define OP_LOAD_LIT 8'h0e
`define OP_MUL_LIT 8'h0d
`define OP_RET_LIT 8'h0c
`define OP_BR_CARRY 8'he2
`define OP_BR_OVF 8'he4
`define OP_PTR_W1 8'hee
`define OP_PTR_W1_ZERO 2'b00
// upper twelve bits
`define OP_BANK_HI 12'h010
`define OP_TABLE_HI 12'h000
`define TBL_READ 2'b10
`define TBL_WRITE 2'b11
`define TBL_NONE 2'b00
`define TBL_POST_INC 2'b01
`define TBL_POST_DEC 2'b10
`define TBL_PRE_INC 2'b11
// file-register groups
`define OP_AND_FILE 6'h05
`define OP_BIT_INV 4'h7
`define OP_CMP_EQ 7'h31
// data addressing
`define IDX_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h80
`define ACCESS_LOW_PAGE 4'h0
`define ACCESS_HIGH_PAGE 4'hf
`define PORT_ADDR 12'hf82
`define TIMER_ZERO_COUNTER_ADDR 12'hfd6
`define DMEM_WORDS 4096
`define PTR_SLOTS 4
// program counter
`define PC_STEP 21'h000002
`define PC_RST 21'h000000
`define TBLPTR_STEP 21'h000001
// register bus
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ACCUM 8'h08
`define REG_PC 8'h0c
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CTRL_RST 2'b01
`define CTRL_RUN_BIT 0
`define CTRL_EXT_BIT 1
`endif

// File: core/cpu8_pkg.sv
package cpu8_pkg;
   // exec -> idle/table flips one bit; exec -> skip/pointer second cycle flips two
   typedef enum logic [2:0] {
      S_EXEC = 3'b000,
      S_IDLE = 3'b001,
      S_SKIP = 3'b011,
      S_SKIP2 = 3'b111,
      S_TBL = 3'b010,
      S_LOAD_POINTER_LITERAL = 3'b110
   } phase_t;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } flags_t;

   typedef struct packed {
      phase_t st;
      logic [20:0] pc;
      logic [7:0] acc;
      flags_t fl;
      logic [3:0] bank_select_register;
      logic [3:0][11:0] file_pointer;
      logic [1:0] ptr_sel;
      logic [3:0] ptr_hi;
      logic [20:0] tblptr;
      logic [7:0] tablat;
      logic [1:0] tbl_post;
      logic tbl_re;
      logic tbl_we;
      logic [15:0] prod;
      logic [7:0] port_latch;
      logic presc_clr;
      logic stack_pop;
      logic [1:0] ctrl;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [1:0] w_data;
      logic w_strb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } core_state_t;
endpackage : cpu8_pkg

// File: core/cpu8_decode_exec.sv
`timescale 1ns/1ps
`include "cpu8_params.svh"
module cpu8_decode_exec (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] instr,
   output logic [20:0] pc,
   input wire logic [20:0] ret_addr,
   output logic stack_pop,
   output logic [20:0] tbl_addr,
   output logic tbl_re,
   output logic tbl_we,
   output logic [7:0] tbl_wdata,
   input wire logic [7:0] tbl_rdata,
   input wire logic [7:0] port_pins,
   output logic [7:0] port_latch,
   input wire logic presc_assigned,
   output logic presc_clr,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import cpu8_pkg::*;

   core_state_t s_q, s_d;
   logic [7:0] dmem [0:`DMEM_WORDS-1];
   logic [11:0] daddr;
   logic [7:0] rd, res, lit, op_b, opc, fb;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [20:0] br_target;
   logic dm_we, go, cin;

   assign go = aresetn && (s_q.st == S_EXEC) && s_q.ctrl[`CTRL_RUN_BIT];
   assign lit = instr[7:0];
   assign fb = instr[7:0];
   assign opc = instr[15:8];
   assign br_target = s_q.pc + `PC_STEP + {{12{lit[7]}}, lit, 1'b0};

   always_comb begin
      if (instr[8]) begin
         daddr = {s_q.bank_select_register, fb};
      end else if (s_q.ctrl[`CTRL_EXT_BIT] && fb <= `IDX_LIMIT) begin
         daddr = s_q.file_pointer[2] + {4'h0, fb};
      end else if (fb < `ACCESS_SPLIT) begin
         daddr = {`ACCESS_LOW_PAGE, fb};
      end else begin
         daddr = {`ACCESS_HIGH_PAGE, fb};
      end
   end

   // port reads see the pins so read-modify-write keeps pin truth
   assign rd = (daddr == `PORT_ADDR) ? port_pins : dmem[daddr];

   // subtract is literal + ~acc + 1, carry meaning no borrow
   assign cin = (opc == `OP_SUB_LIT);
   assign op_b = cin ? ~s_q.acc : s_q.acc;
   assign sum9 = {1'b0, lit} + {1'b0, op_b} + {8'h00, cin};
   assign sum5 = {1'b0, lit[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};

   always_comb begin
      s_d = s_q;
      s_d.presc_clr = 1'b0;
      s_d.stack_pop = 1'b0;
      s_d.tbl_re = 1'b0;
      s_d.tbl_we = 1'b0;
      dm_we = 1'b0;
      res = 8'h00;
      case (s_q.st)
         S_EXEC: begin
            if (go) begin
               s_d.pc = s_q.pc + `PC_STEP;
               if (opc == `OP_ADD_LIT || opc == `OP_SUB_LIT) begin
                  s_d.acc = sum9[7:0];
                  s_d.fl.c = sum9[8];
                  s_d.fl.dc = sum5[4];
                  s_d.fl.z = (sum9[7:0] == 8'h00);
                  s_d.fl.n = sum9[7];
                  s_d.fl.ov = (lit[7] == op_b[7]) && (sum9[7] != lit[7]);
               end else if (opc == `OP_AND_LIT || opc == `OP_OR_LIT ||
                            opc == `OP_XOR_LIT) begin
                  if (opc == `OP_AND_LIT) begin
                     res = lit & s_q.acc;
                  end else if (opc == `OP_OR_LIT) begin
                     res = lit | s_q.acc;
                  end else begin
                     res = lit ^ s_q.acc;
                  end
                  s_d.acc = res;
                  s_d.fl.z = (res == 8'h00);
                  s_d.fl.n = res[7];
               end else if (opc == `OP_LOAD_LIT) begin
                  s_d.acc = lit;
               end else if (opc == `OP_MUL_LIT) begin
                  s_d.prod = 16'(lit * s_q.acc);
               end else if (opc == `OP_RET_LIT) begin
                  s_d.acc = lit;
                  s_d.pc = ret_addr;
                  s_d.stack_pop = 1'b1;
                  s_d.st = S_IDLE;
               end else if (instr[15:4] == `OP_BANK_HI) begin
                  s_d.bank_select_register = instr[3:0];
               end else if (opc == `OP_PTR_W1 &&
                            instr[7:6] == `OP_PTR_W1_ZERO) begin
                  s_d.ptr_sel = instr[5:4];
                  s_d.ptr_hi = instr[3:0];
                  s_d.st = S_LOAD_POINTER_LITERAL;
               end else if (instr[15:4] == `OP_TABLE_HI && instr[3]) begin
                  if (instr[1:0] == `TBL_PRE_INC) begin
                     s_d.tblptr = s_q.tblptr + `TBLPTR_STEP;
                  end
                  s_d.tbl_post = instr[1:0];
                  s_d.tbl_re = !instr[2];
                  s_d.tbl_we = instr[2];
                  s_d.st = S_TBL;
               end else if (opc == `OP_BR_CARRY) begin
                  if (s_q.fl.c) begin
                     s_d.pc = br_target;
                     s_d.st = S_IDLE;
                  end
               end else if (opc == `OP_BR_OVF) begin
                  if (s_q.fl.ov) begin
                     s_d.pc = br_target;
                     s_d.st = S_IDLE;
                  end
               end else if (instr[15:10] == `OP_AND_FILE) begin
                  res = s_q.acc & rd;
                  s_d.fl.z = (res == 8'h00);
                  s_d.fl.n = res[7];
                  if (instr[9]) begin
                     dm_we = 1'b1;
                  end else begin
                     s_d.acc = res;
                  end
               end else if (instr[15:12] == `OP_BIT_INV) begin
                  res = rd ^ (8'h01 << instr[11:9]);
                  dm_we = 1'b1;
               end else if (instr[15:9] == `OP_CMP_EQ) begin
                  if (rd == s_q.acc) begin
                     s_d.st = S_SKIP;
                  end
               end
               if (dm_we && daddr == `PORT_ADDR) begin
                  s_d.port_latch = res;
               end
               if (dm_we && daddr == `TIMER_ZERO_COUNTER_ADDR && presc_assigned) begin
                  s_d.presc_clr = 1'b1;
               end
            end
         end
         S_IDLE: begin
            s_d.st = S_EXEC;
         end
         S_SKIP: begin
            // fetched word is dropped; a two-word one costs one more cycle
            s_d.pc = s_q.pc + `PC_STEP;
            s_d.st = (opc == `OP_PTR_W1) ? S_SKIP2 : S_EXEC;
         end
         S_SKIP2: begin
            s_d.pc = s_q.pc + `PC_STEP;
            s_d.st = S_EXEC;
         end
         S_LOAD_POINTER_LITERAL: begin
            s_d.file_pointer[s_q.ptr_sel] = {s_q.ptr_hi, lit};
            s_d.pc = s_q.pc + `PC_STEP;
            s_d.st = S_EXEC;
         end
         S_TBL: begin
            if (s_q.tbl_re) begin
               s_d.tablat = tbl_rdata;
            end
            if (s_q.tbl_post == `TBL_POST_INC) begin
               s_d.tblptr = s_q.tblptr + `TBLPTR_STEP;
            end else if (s_q.tbl_post == `TBL_POST_DEC) begin
               s_d.tblptr = s_q.tblptr - `TBLPTR_STEP;
            end
            s_d.st = S_EXEC;
         end
         default: begin
            s_d.st = S_EXEC;
         end
      endcase

      // register bus slave: address and data taken in either order
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (awvalid && s_q.awready) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (wvalid && s_q.wready) begin
         s_d.w_got = 1'b1;
         s_d.w_data = wdata[1:0];
         s_d.w_strb0 = wstrb[0];
      end
      if (s_d.aw_got && s_d.w_got && !s_d.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `RESP_OKAY;
         if (s_d.aw_addr == `REG_CTRL) begin
            if (s_d.w_strb0) begin
               s_d.ctrl = s_d.w_data;
            end
         end else if (s_d.aw_addr != `REG_STATUS &&
                      s_d.aw_addr != `REG_ACCUM &&
                      s_d.aw_addr != `REG_PC) begin
            s_d.bresp = `RESP_SLVERR;
         end
      end
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready = !s_d.w_got && !s_d.bvalid;

      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `RESP_OKAY;
         case (araddr)
            `REG_CTRL: s_d.rdata = {30'h0, s_q.ctrl};
            `REG_STATUS: s_d.rdata = {19'h0, s_q.bank_select_register, 4'h0, s_q.fl};
            `REG_ACCUM: s_d.rdata = {24'h0, s_q.acc};
            `REG_PC: s_d.rdata = {11'h0, s_q.pc};
            default: begin
               s_d.rdata = 32'h0;
               s_d.rresp = `RESP_SLVERR;
            end
         endcase
      end
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.st <= S_EXEC;
         s_q.pc <= `PC_RST;
         s_q.ctrl <= `CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // data memory holds no reset; only executed instructions write it
   always_ff @(posedge aclk) begin
      if (dm_we) begin
         dmem[daddr] <= res;
      end
   end

   assign pc = s_q.pc;
   assign stack_pop = s_q.stack_pop;
   assign tbl_addr = s_q.tblptr;
   assign tbl_re = s_q.tbl_re;
   assign tbl_we = s_q.tbl_we;
   assign tbl_wdata = s_q.tablat;
   assign port_latch = s_q.port_latch;
   assign presc_clr = s_q.presc_clr;
   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rresp = s_q.rresp;
   assign rdata = s_q.rdata;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_add_lit;
      go && opc == `OP_ADD_LIT |=>
         s_q.acc == 8'($past(s_q.acc) + $past(lit));
   endproperty
   a_add_lit: assert property (p_add_lit) else $error("add literal wrong");

   property p_and_lit;
      go && opc == `OP_AND_LIT |=>
         s_q.acc == ($past(s_q.acc) & $past(lit)) &&
         {s_q.fl.c, s_q.fl.dc, s_q.fl.ov} ==
         $past({s_q.fl.c, s_q.fl.dc, s_q.fl.ov});
   endproperty
   a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

   property p_flags_kept;
      go && (opc == `OP_LOAD_LIT || opc == `OP_MUL_LIT) |=>
         s_q.fl == $past(s_q.fl) && s_q.st == S_EXEC;
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("flags moved");

   property p_bank;
      go && instr[15:4] == `OP_BANK_HI |=> s_q.bank_select_register == $past(instr[3:0]);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select not loaded");

   property p_ret;
      go && opc == `OP_RET_LIT |=>
         s_q.st == S_IDLE && s_q.acc == $past(lit) && s_q.stack_pop
         ##1 s_q.st == S_EXEC;
   endproperty
   a_ret: assert property (p_ret) else $error("return literal wrong");

   property p_ptr;
      go && opc == `OP_PTR_W1 && instr[7:4] == 4'h0 |=>
         s_q.st == S_LOAD_POINTER_LITERAL ##1 s_q.file_pointer[0] == {$past(instr[3:0], 2),
         $past(lit)};
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer load wrong");

   property p_tbl_read;
      go && instr[15:2] == {`OP_TABLE_HI, `TBL_READ} |=>
         s_q.st == S_TBL && s_q.tbl_re ##1 s_q.st == S_EXEC && !s_q.tbl_re;
   endproperty
   a_tbl_read: assert property (p_tbl_read) else $error("table read wrong");

   property p_presc;
      go && dm_we && daddr == `TIMER_ZERO_COUNTER_ADDR && presc_assigned |=> s_q.presc_clr;
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler not cleared");

   property p_br_carry;
      go && opc == `OP_BR_CARRY && s_q.fl.c |=>
         s_q.pc == $past(br_target) && s_q.st == S_IDLE;
   endproperty
   a_br_carry: assert property (p_br_carry) else $error("branch wrong");

   property p_skip;
      go && instr[15:9] == `OP_CMP_EQ && rd == s_q.acc |=>
         s_q.st == S_SKIP && s_q.fl == $past(s_q.fl);
   endproperty
   a_skip: assert property (p_skip) else $error("skip not taken");

   property p_quiet;
      (s_q.st == S_IDLE || s_q.st == S_SKIP || s_q.st == S_SKIP2) |->
         !dm_we ##1 s_q.fl == $past(s_q.fl) && s_q.acc == $past(s_q.acc);
   endproperty
   a_quiet: assert property (p_quiet) else $error("idle cycle had effect");
endmodule : cpu8_decode_exec

// File: test/cpu8_prog_mem_model.sv
`timescale 1ns/1ps
module cpu8_prog_mem_model #(
   parameter logic [20:0] RET_TARGET = 21'h000100
) (
   input wire logic aclk,
   input wire logic [20:0] pc,
   output logic [15:0] instr,
   output logic [20:0] ret_addr,
   input wire logic [20:0] tbl_addr,
   input wire logic tbl_re,
   input wire logic tbl_we,
   input wire logic [7:0] tbl_wdata,
   output logic [7:0] tbl_rdata
);
   logic [15:0] mem [256];
   logic [7:0] tab [256];
   logic [29:0] log_q [$];
   // words past the loaded image read as idle cycles
   assign instr = (pc[20:9] == 12'h000) ? mem[pc[8:1]] : 16'h0000;
   assign ret_addr = RET_TARGET;
   // read data only holds in the strobe cycle, garbage elsewhere
   assign tbl_rdata = tbl_re ? tab[tbl_addr[7:0]] : ~tab[tbl_addr[7:0]];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'h0000;
         tab[i] = i[7:0] ^ 8'h5a;
      end
   end
   // strobes stand a whole cycle; mid-cycle sampling avoids the edge race
   always @(negedge aclk) begin
      if (tbl_re === 1'b1 || tbl_we === 1'b1) begin
         log_q.push_back({tbl_we, tbl_wdata, tbl_addr});
         if (tbl_we === 1'b1) tab[tbl_addr[7:0]] <= tbl_wdata;
      end
   end
endmodule : cpu8_prog_mem_model

// File: test/cpu8_instr_decode_exec_subset_tb.sv
`timescale 1ns/1ps
`include "cpu8_params.svh"
module cpu8_instr_decode_exec_subset_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] instr;
   logic [20:0] pc, ret_addr, tbl_addr, base;
   logic stack_pop, tbl_re, tbl_we, presc_clr;
   logic [7:0] tbl_wdata, tbl_rdata, port_latch;
   logic [7:0] port_pins = 8'ha5;
   logic presc_assigned = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [20:0] end_addr = 21'h1fffff;
   logic [20:0] offs [8] = '{0, 2, 2, 1, 1, 1, 2, 2};
   int n_mismatch = 0, n_compared = 0, cyc = 0, hit = 0;
   int n_presc = 0, n_pop = 0;

   always #50 aclk = ~aclk;

   cpu8_decode_exec cpu8_decode_exec_i (.aclk, .aresetn, .instr, .pc,
      .ret_addr, .stack_pop, .tbl_addr, .tbl_re, .tbl_we, .tbl_wdata,
      .tbl_rdata, .port_pins, .port_latch, .presc_assigned, .presc_clr,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);

   cpu8_prog_mem_model cpu8_prog_mem_model_i (.aclk, .pc, .instr,
      .ret_addr, .tbl_addr, .tbl_re, .tbl_we, .tbl_wdata, .tbl_rdata);

   // edge count since release, and the edge at which pc hits the end
   // pulses are read 1 ns after the edge, once the registers settled
   always @(posedge aclk) begin
      if (aresetn !== 1'b1) begin
         cyc = 0;
         hit = 0;
         n_presc = 0;
         n_pop = 0;
      end else begin
         cyc = cyc + 1;
      end
      #1;
      if (aresetn === 1'b1 && presc_clr === 1'b1) n_presc++;
      if (aresetn === 1'b1 && stack_pop === 1'b1) n_pop++;
      if (aresetn === 1'b1 && pc === end_addr && hit == 0) hit = cyc;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task results;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   // handshakes are judged mid-cycle on what the next edge will sample
   task axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw_hs, w_hs, b_hs;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_hs = 1'b0;
      while (!b_hs) begin
         @(negedge aclk);
         aw_hs = ((awvalid && awready) === 1'b1);
         w_hs = ((wvalid && wready) === 1'b1);
         b_hs = (bvalid === 1'b1);
         rsp = bresp;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) bready <= 1'b0;
      end
   endtask : axi_write

   task axi_read(input logic [7:0] a, output logic [31:0] d);
      logic ar_hs, r_hs;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_hs = 1'b0;
      while (!r_hs) begin
         @(negedge aclk);
         ar_hs = ((arvalid && arready) === 1'b1);
         r_hs = (rvalid === 1'b1);
         d = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) rready <= 1'b0;
      end
   endtask : axi_read

   // loads the image behind pre idle words, then runs it from reset
   task start(input logic [15:0] p [$], input logic [20:0] e, input int pre);
      @(posedge aclk);
      aresetn <= 1'b0;
      for (int i = 0; i < 256; i++) begin
         cpu8_prog_mem_model_i.mem[i] = 16'h0000;
         if (i >= pre && i - pre < p.size())
            cpu8_prog_mem_model_i.mem[i] = p[i-pre];
      end
      cpu8_prog_mem_model_i.log_q.delete();
      end_addr = e;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : start

   task verify(input int exp_cyc, input logic [7:0] exp_acc);
      repeat (40) @(posedge aclk);
      check(hit, exp_cyc);
      axi_read(`REG_ACCUM, rd);
      check(rd, {24'h0, exp_acc});
   endtask : verify

   initial begin
      start('{16'h0e80, 16'h0f80, 16'h0e5a, 16'h0d03, 16'h010a, 16'he201,
         16'h0e11, 16'he401, 16'h0e22}, 21'h12, 0);
      axi_read(`REG_CTRL, rd);
      check(rd, 32'h1);
      verify(8, 8'h5a);
      axi_read(`REG_STATUS, rd);
      check(rd, 32'h140d);
      axi_read(8'h10, rd);
      check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
      start('{16'h0e01, 16'h0810, 16'h0a0f, 16'h0980, 16'h0bc0, 16'he401,
         16'h0e33}, 21'h0e, 0);
      verify(7, 8'h33);
      axi_read(`REG_STATUS, rd);
      check(rd, 32'h11);
      start('{16'h0c77}, 21'h102, 0);
      cpu8_prog_mem_model_i.mem[8'h80] = 16'h010c;
      verify(3, 8'h77);
      check(n_pop, 1);
      start('{16'hee2f, 16'hf072, 16'h0e3c, 16'h1410, 16'h1682, 16'h7e82,
         16'h7f82, 16'hf0ff}, 21'h30, 16);
      axi_write(`REG_CTRL, 32'h3);
      check({30'h0, rsp}, {30'h0, `RESP_OKAY});
      verify(24, 8'h24);
      check({24'h0, port_latch}, 32'h25);
      start('{16'h0e66, 16'h0009, 16'h000b, 16'h000a, 16'h0008, 16'h000c,
         16'h000d, 16'h000e, 16'h000f}, 21'h12, 0);
      verify(16, 8'h66);
      check(cpu8_prog_mem_model_i.log_q.size(), 8);
      base = cpu8_prog_mem_model_i.log_q[0][20:0];
      for (int i = 0; i < 8; i++) begin
         rd = {10'h0, cpu8_prog_mem_model_i.log_q[i][29],
            cpu8_prog_mem_model_i.log_q[i][20:0] - base};
         check(rd, {10'h0, i >= 4, offs[i]});
      end
      rd = {24'h0, cpu8_prog_mem_model_i.log_q[4][28:21]};
      check(rd, {24'h0, (base[7:0] + 8'h01) ^ 8'h5a});
      start('{16'h14d6, 16'h16d6, 16'h0e11, 16'h6282, 16'h0ea5, 16'h6282,
         16'h0e99, 16'h6282, 16'hee2f, 16'hf072}, 21'h14, 0);
      verify(10, 8'ha5);
      check(n_presc, 1);
      // prescaler not assigned: timer write must leave it alone
      presc_assigned <= 1'b0;
      start('{16'h16d6}, 21'h2, 0);
      verify(1, 8'h00);
      check(n_presc, 0);
      results();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
endmodule : cpu8_instr_decode_exec_subset_tb
